/* pkg/tps_pkg.sv */
// Package with register map, field positions and prescaler constants for the timer prescaler block
package tps_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CTRL_A = 8'h08;
  localparam logic [7:0] ADDR_CTRL_B = 8'h0c;
  localparam logic [7:0] ADDR_PRESC = 8'h10;
  localparam logic [7:0] ADDR_CMP = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_COUNT = 8'h1c;
  localparam int OVF0_BIT = 0;
  localparam int CMP0_BIT = 1;
  localparam int PSR_BIT = 0;
  localparam int GIE_BIT = 0;
  localparam int PCPWM_BIT = 3;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;
  typedef enum logic [2:0]
  {
    TPS_CS_STOP = 3'h0,
    TPS_CS_DIV1 = 3'h1,
    TPS_CS_DIV8 = 3'h2,
    TPS_CS_DIV64 = 3'h3,
    TPS_CS_DIV256 = 3'h4,
    TPS_CS_DIV1024 = 3'h5,
    TPS_CS_EXT_FALL = 3'h6,
    TPS_CS_EXT_RISE = 3'h7
  } tps_cs_t;
  typedef enum logic [1:0]
  {
    TPS_DIR_UP = 2'b00,
    TPS_DIR_DOWN = 2'b01
  } tps_dir_t;
endpackage

/* pkg/tps_tick_if.sv */
// Interface carrying prescaler taps, clock selects and resulting ticks
interface tps_tick_if;
  logic [3:0] taps;
  logic [2:0] sel_a;
  logic [2:0] sel_b;
  logic pin_a;
  logic pin_b;
  logic tick_a;
  logic tick_b;
  modport src (output taps, output sel_a, output sel_b, output pin_a, output pin_b, input tick_a, input tick_b);
  modport sel (input taps, input sel_a, input sel_b, input pin_a, input pin_b, output tick_a, output tick_b);
endinterface

/* rtl/tps_clock_sel.sv */
// Per-timer clock source selection with count pin synchronizers and edge detectors
module tps_clock_sel
  import tps_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Tick bus
  tps_tick_if.sel tb
);
  logic [1:0] sync_a_q;
  logic [1:0] sync_b_q;
  logic prev_a_q;
  logic prev_b_q;

  function automatic logic pick(input logic [2:0] cs, input logic [3:0] taps, input logic s, input logic p);
    case (cs)
      TPS_CS_STOP: pick = 1'b0;
      TPS_CS_DIV1: pick = 1'b1;
      TPS_CS_DIV8: pick = taps[0];
      TPS_CS_DIV64: pick = taps[1];
      TPS_CS_DIV256: pick = taps[2];
      TPS_CS_DIV1024: pick = taps[3];
      TPS_CS_EXT_FALL: pick = p & ~s;
      TPS_CS_EXT_RISE: pick = s & ~p;
      default: pick = 1'b0;
    endcase
  endfunction

  wire logic tick_a_d = pick(tb.sel_a, tb.taps, sync_a_q[1], prev_a_q);
  wire logic tick_b_d = pick(tb.sel_b, tb.taps, sync_b_q[1], prev_b_q);

  // Two-stage sampling on the rising edge stands in for the latch plus register
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_a_q <= 2'h0;
      sync_b_q <= 2'h0;
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
    end
    else
    begin
      sync_a_q <= {sync_a_q[0], tb.pin_a}; // RQ12 RQ18
      sync_b_q <= {sync_b_q[0], tb.pin_b}; // RQ12 RQ18
      prev_a_q <= sync_a_q[1];
      prev_b_q <= sync_b_q[1];
    end
  end

  // Tick is not registered again here, so a pin edge reaches the counter within three cycles
  assign tb.tick_a = tick_a_d; // RQ13 RQ17 RQ20
  assign tb.tick_b = tick_b_d; // RQ13 RQ17 RQ20

  AST_RISE_TICK: assert property (@(posedge clock) disable iff (!nrst)
    (tb.sel_a == TPS_CS_EXT_RISE && sync_a_q[1] && !prev_a_q) |-> tb.tick_a) // RQ13
    else $error("rising pin edge gave no tick");
  AST_STOP_NO_TICK: assert property (@(posedge clock) disable iff (!nrst)
    (tb.sel_a == TPS_CS_STOP) |-> !tb.tick_a) // RQ20
    else $error("tick while stopped");
endmodule

/* rtl/tps_top.sv */
// Shared timer prescaler with timer 0 compare and overflow flag logic behind an APB slave
// Contract
// RQ1: Compare flag with enable and global requests interrupt
// RQ2: Overflow flag with enable and global requests interrupt
// RQ3: Count equal compare value sets compare flag
// RQ4: Compare flag clears on vector or write-one
// RQ5: Overflow sets flag; clears on vector/write-one
// RQ6: Phase-correct mode sets overflow at bottom turn
// RQ7: One prescaler, independent clock select per timer
// RQ8: Select one counts every clock cycle
// RQ9: Taps divide by 8, 64, 256, 1024
// RQ10: Prescaler runs free; first count 1..N+1
// RQ11: Prescaler reset restarts period for both timers
// RQ12: Count pin sampled each clock, then edge-detected
// RQ13: Select 7 rising, select 6 falling edges
// RQ14: Pin edge updates counter about three cycles later
// RQ15: Software toggles external clock only on stable pin
// RQ16: External clock slower than half system clock
// RQ17: External pulses bypass the prescaler divider
// RQ18: Pin edges synchronized to system clock
// RQ19: Prescaler reset bit self-clears, reads zero
// RQ20: Select zero stops the counter
// RQ21: Hardware set beats software clear
//
// The implementer's own choices: register access over APB and the address map.
module tps_top
  import tps_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count pins
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  // Core side
  input wire logic core_int_enable,
  input wire logic cmp0_vector_ack,
  input wire logic ovf0_vector_ack,
  output logic cmp0_irq,
  output logic ovf0_irq,
  // Timer ticks
  output logic timer_a_tick,
  output logic timer_b_tick
);
  import tps_pkg::*;

  tps_tick_if tb ();

  logic [9:0] presc_q;
  logic [1:0] flags_q;
  logic [1:0] mask_q;
  logic [3:0] ctrl_a_q;
  logic [2:0] ctrl_b_q;
  logic [7:0] cmp0_value_q;
  logic [7:0] count_q;
  tps_dir_t dir_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic cmp0_irq_q;
  logic ovf0_irq_q;
  logic tick_a_q;
  logic tick_b_q;
  logic psr_q;

  // APB decode
  wire logic acc = psel & penable & ~pready_q;
  wire logic wr = acc & pwrite;
  wire logic hit_flags = paddr == ADDR_FLAGS;
  wire logic hit_mask = paddr == ADDR_MASK;
  wire logic hit_ctrl_a = paddr == ADDR_CTRL_A;
  wire logic hit_ctrl_b = paddr == ADDR_CTRL_B;
  wire logic hit_presc = paddr == ADDR_PRESC;
  wire logic hit_cmp = paddr == ADDR_CMP;
  wire logic hit_status = paddr == ADDR_STATUS;
  wire logic hit_count = paddr == ADDR_COUNT;
  wire logic mapped = hit_flags | hit_mask | hit_ctrl_a | hit_ctrl_b | hit_presc | hit_cmp | hit_status | hit_count;
  wire logic psr_wr = wr & hit_presc & pwdata[PSR_BIT];

  // Prescaler taps: a tap fires when its low bits roll over
  function automatic logic tap(input logic [9:0] cnt, input logic [9:0] m);
    tap = (cnt & m) == m;
  endfunction

  wire logic [3:0] taps = {tap(presc_q, DIV1024_MASK), tap(presc_q, DIV256_MASK),
                           tap(presc_q, DIV64_MASK), tap(presc_q, DIV8_MASK)}; // RQ9

  assign tb.taps = psr_q ? 4'h0 : taps;
  assign tb.sel_a = ctrl_a_q[2:0]; // RQ7
  assign tb.sel_b = ctrl_b_q; // RQ7
  assign tb.pin_a = count_pin_a;
  assign tb.pin_b = count_pin_b;

  tps_clock_sel u_sel (
    .clock(clock),
    .nrst(nrst),
    .tb(tb)
  );

  // Timer 0 counter: normal wrap or phase-correct up/down
  wire logic pcpwm = ctrl_a_q[PCPWM_BIT];
  wire logic step = tb.tick_a;
  wire logic at_max = count_q == 8'hff;
  wire logic at_zero = count_q == 8'h00;
  wire logic ovf_evt = step & (pcpwm ? (dir_q == TPS_DIR_DOWN && count_q == 8'h01) : at_max); // RQ5 RQ6
  wire logic cmp_evt = step & (count_q == cmp0_value_q); // RQ3
  wire logic count_wr = wr & hit_count;

  function automatic logic [7:0] next_count(input logic [7:0] c, input logic pc, input tps_dir_t d);
    if (pc && d == TPS_DIR_DOWN)
      next_count = c - 8'h01;
    else
      next_count = c + 8'h01;
  endfunction

  wire tps_dir_t dir_d = !pcpwm ? TPS_DIR_UP :
                         (dir_q == TPS_DIR_UP && count_q == 8'hfe) ? TPS_DIR_DOWN :
                         (dir_q == TPS_DIR_DOWN && count_q == 8'h01) ? TPS_DIR_UP : dir_q;

  // Flags: hardware set wins over write-one and vector clears
  wire logic [1:0] set_v = {cmp_evt, ovf_evt};
  wire logic [1:0] w1c_v = (wr & hit_flags) ? {pwdata[CMP0_BIT], pwdata[OVF0_BIT]} : 2'b00;
  wire logic [1:0] ack_v = {cmp0_vector_ack, ovf0_vector_ack};
  wire logic [1:0] flags_d = set_v | (flags_q & ~(w1c_v | ack_v)); // RQ4 RQ5 RQ21

  wire logic [31:0] rd_mux =
    hit_flags ? {30'h0, flags_q} :
    hit_mask ? {30'h0, mask_q} :
    hit_ctrl_a ? {28'h0, ctrl_a_q} :
    hit_ctrl_b ? {29'h0, ctrl_b_q} :
    hit_cmp ? {24'h0, cmp0_value_q} :
    hit_count ? {24'h0, count_q} :
    hit_status ? {29'h0, dir_q == TPS_DIR_DOWN, tick_b_q, tick_a_q} :
    32'h0; // RQ19

  // Free-running prescaler, restarted by the reset bit for both timers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      presc_q <= 10'h000;
      psr_q <= 1'b0;
    end
    else
    begin
      psr_q <= psr_wr; // RQ19
      presc_q <= psr_wr ? 10'h000 : presc_q + 10'h001; // RQ10 RQ11
    end
  end

  // APB register file
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_q <= MASK_RST[1:0];
      ctrl_a_q <= 4'h0;
      ctrl_b_q <= 3'h0;
      cmp0_value_q <= 8'h00;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc & ~mapped;
      prdata_q <= (acc & ~pwrite) ? rd_mux : 32'h0;
      if (wr && hit_mask)
        mask_q <= pwdata[1:0];
      if (wr && hit_ctrl_a)
        ctrl_a_q <= pwdata[3:0];
      if (wr && hit_ctrl_b)
        ctrl_b_q <= pwdata[2:0];
      if (wr && hit_cmp)
        cmp0_value_q <= pwdata[7:0];
    end
  end

  // Timer 0 counter and flags
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      count_q <= 8'h00;
      dir_q <= TPS_DIR_UP;
      flags_q <= FLAGS_RST[1:0];
    end
    else
    begin
      flags_q <= flags_d;
      if (count_wr)
        count_q <= pwdata[7:0];
      else if (step)
      begin
        count_q <= next_count(count_q, pcpwm, dir_q); // RQ8 RQ14
        dir_q <= dir_d;
      end
    end
  end

  // Interrupt requests and registered outputs
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp0_irq_q <= 1'b0;
      ovf0_irq_q <= 1'b0;
      tick_a_q <= 1'b0;
      tick_b_q <= 1'b0;
    end
    else
    begin
      cmp0_irq_q <= flags_d[CMP0_BIT] & mask_q[CMP0_BIT] & core_int_enable; // RQ1
      ovf0_irq_q <= flags_d[OVF0_BIT] & mask_q[OVF0_BIT] & core_int_enable; // RQ2
      tick_a_q <= tb.tick_a;
      tick_b_q <= tb.tick_b;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cmp0_irq = cmp0_irq_q;
  assign ovf0_irq = ovf0_irq_q;
  assign timer_a_tick = tick_a_q;
  assign timer_b_tick = tick_b_q;

  AST_CMP_IRQ: assert property (@(posedge clock) disable iff (!nrst)
    (flags_q[CMP0_BIT] && mask_q[CMP0_BIT] && core_int_enable && !cmp0_vector_ack && !w1c_v[1]) |=> cmp0_irq) // RQ1
    else $error("compare irq missing");
  AST_OVF_IRQ: assert property (@(posedge clock) disable iff (!nrst)
    (!mask_q[OVF0_BIT] || !core_int_enable) |=> !ovf0_irq) // RQ2
    else $error("overflow irq while masked");
  AST_CMP_SET: assert property (@(posedge clock) disable iff (!nrst)
    cmp_evt |=> flags_q[CMP0_BIT]) // RQ3
    else $error("compare flag not set");
  AST_CMP_CLR: assert property (@(posedge clock) disable iff (!nrst)
    (flags_q[CMP0_BIT] && cmp0_vector_ack && !cmp_evt) |=> !flags_q[CMP0_BIT]) // RQ4
    else $error("compare flag not cleared by vector");
  AST_OVF_SET: assert property (@(posedge clock) disable iff (!nrst)
    (step && !pcpwm && at_max && !count_wr) |=> flags_q[OVF0_BIT] && count_q == 8'h00) // RQ5
    else $error("overflow flag not set on wrap");
  AST_PC_OVF: assert property (@(posedge clock) disable iff (!nrst)
    (pcpwm && ovf_evt && !count_wr) |=> at_zero && flags_q[OVF0_BIT]) // RQ6
    else $error("phase correct overflow not at bottom");
  AST_DIV1: assert property (@(posedge clock) disable iff (!nrst)
    (tb.sel_a == TPS_CS_DIV1) |-> tb.tick_a) // RQ8
    else $error("divide by one missed a cycle");
  AST_DIV8_GAP: assert property (@(posedge clock) disable iff (!nrst)
    (taps[0] && !psr_wr) |=> !taps[0] [*7]) // RQ9
    else $error("divide by eight tap too frequent");
  AST_PSR_RESTART: assert property (@(posedge clock) disable iff (!nrst)
    psr_wr |=> presc_q == 10'h000 && tb.taps == 4'h0) // RQ11
    else $error("prescaler not restarted");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (!nrst)
    (ovf_evt && w1c_v[0]) |=> flags_q[OVF0_BIT]) // RQ21
    else $error("set lost to clear");
endmodule

/* tb/tps_pin_src.sv */
// External count source driving the count pins
module tps_pin_src #(
  parameter int HALF = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic run,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Half period of HALF cycles keeps the source under a 2.5th of the clock
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 0;
      pin <= 1'b0;
    end
    else if (cnt == HALF - 1)
    begin
      cnt <= 0;
      // Rests low and steady outside a burst
      if (run || pin)
        pin <= !pin;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

/* tb/test_timer_prescaler_and_flag_logic.sv */
// Self-checking bench for the timer prescaler and flag block
module test_timer_prescaler_and_flag_logic;
  timeunit 1ns;
  timeprecision 1ns;
  import tps_pkg::*;
  logic clock, nrst, psel, penable, pwrite, pready, pslverr, pin, run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic core_int_enable, cmp0_vector_ack, ovf0_vector_ack, cmp0_irq, ovf0_irq;
  logic timer_a_tick, timer_b_tick, slv;
  int num_errors, compares, ca, cb, ru, fl, ia, ib, ja, jb;
  int divs[4] = '{8, 64, 256, 1024};

  tps_top dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_pin_a(pin), .count_pin_b(pin), .core_int_enable(core_int_enable),
    .cmp0_vector_ack(cmp0_vector_ack), .ovf0_vector_ack(ovf0_vector_ack), .cmp0_irq(cmp0_irq),
    .ovf0_irq(ovf0_irq), .timer_a_tick(timer_a_tick), .timer_b_tick(timer_b_tick));
  tps_pin_src #(.HALF(3)) src (.clock(clock), .nrst(nrst), .run(run), .pin(pin));

  always #25 clock = !clock;

  task close_out;
    if (num_errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (k == 20)
    begin
      chk("pready", 1, pready);
      close_out;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask

  task count(input int n);
    logic p;
    p = pin;
    repeat (n)
    begin
      @(posedge clock);
      ca += (timer_a_tick === 1'b1);
      cb += (timer_b_tick === 1'b1);
      ru += (pin === 1'b1 && p === 1'b0);
      fl += (pin === 1'b0 && p === 1'b1);
      p = pin;
    end
  endtask

  task first_tick(output int xa, output int xb);
    xa = -1;
    xb = -1;
    for (int k = 0; k < 20; k++)
    begin
      @(posedge clock);
      if (xa < 0 && timer_a_tick === 1'b1)
        xa = k;
      if (xb < 0 && timer_b_tick === 1'b1)
        xb = k;
    end
  endtask

  task wait_irq(input bit ovf);
    int k;
    k = 0;
    while ((ovf ? ovf0_irq : cmp0_irq) !== 1'b1 && k < 300)
    begin
      @(posedge clock);
      k++;
    end
    chk("irq wait", 1, k < 300);
  endtask

  initial
  begin
    clock = 0;
    nrst = 0;
    {psel, penable, pwrite, run, core_int_enable, cmp0_vector_ack, ovf0_vector_ack} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdchk("flags rst", ADDR_FLAGS, {24'h0, FLAGS_RST});
    rdchk("mask rst", ADDR_MASK, {24'h0, MASK_RST});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 1, slv);
    wr(ADDR_PRESC, 32'h1);
    rdchk("presc bit", ADDR_PRESC, 32'h0);
    wr(ADDR_CTRL_A, TPS_CS_DIV1);
    wr(ADDR_CTRL_B, TPS_CS_STOP);
    {ca, cb} = '0;
    count(16);
    chk("div1 ticks", 16, ca);
    chk("stop ticks", 0, cb);
    rdchk("status div1", ADDR_STATUS, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL_A, 32'(i + 2));
      wr(ADDR_CTRL_B, 32'(5 - i));
      {ca, cb} = '0;
      repeat (2) @(posedge clock);
      count(4 * divs[i > 1 ? i : 3 - i]);
      chk("tap a", 4 * divs[i > 1 ? i : 3 - i] / divs[i], ca);
      chk("tap b", 4 * divs[i > 1 ? i : 3 - i] / divs[3 - i], cb);
    end
    wr(ADDR_CTRL_A, TPS_CS_DIV8);
    wr(ADDR_CTRL_B, TPS_CS_DIV8);
    wr(ADDR_PRESC, 32'h1);
    first_tick(ia, ib);
    repeat (3) @(posedge clock);
    wr(ADDR_PRESC, 32'h1);
    first_tick(ja, jb);
    chk("restart a", ia, ja);
    chk("restart b", ia, jb);
    wr(ADDR_CTRL_A, TPS_CS_STOP);
    wr(ADDR_FLAGS, 32'h3);
    rdchk("w1c", ADDR_FLAGS, 32'h0);
    wr(ADDR_COUNT, 32'h10);
    wr(ADDR_CMP, 32'h14);
    wr(ADDR_MASK, 32'h2);
    core_int_enable <= 1'b1;
    wr(ADDR_CTRL_A, TPS_CS_DIV1);
    wait_irq(0);
    wr(ADDR_CTRL_A, TPS_CS_STOP);
    rdchk("cmp flag", ADDR_FLAGS, 32'h2);
    wr(ADDR_FLAGS, 32'h0);
    rdchk("write zero", ADDR_FLAGS, 32'h2);
    cmp0_vector_ack <= 1'b1;
    @(posedge clock);
    cmp0_vector_ack <= 1'b0;
    rdchk("cmp ack", ADDR_FLAGS, 32'h0);
    chk("cmp irq low", 0, cmp0_irq);
    wr(ADDR_COUNT, 32'hfd);
    wr(ADDR_MASK, 32'h1);
    wr(ADDR_CTRL_A, TPS_CS_DIV1);
    wait_irq(1);
    wr(ADDR_CTRL_A, TPS_CS_STOP);
    rdchk("ovf flag", ADDR_FLAGS, 32'h1);
    core_int_enable <= 1'b0;
    repeat (2) @(posedge clock);
    chk("ovf gated", 0, ovf0_irq);
    ovf0_vector_ack <= 1'b1;
    @(posedge clock);
    ovf0_vector_ack <= 1'b0;
    rdchk("ovf ack", ADDR_FLAGS, 32'h0);
    core_int_enable <= 1'b1;
    wr(ADDR_COUNT, 32'hfc);
    wr(ADDR_CTRL_A, 32'h9);
    wait_irq(1);
    wr(ADDR_CTRL_A, TPS_CS_STOP);
    rdchk("pc flags", ADDR_FLAGS, 32'h3);
    wr(ADDR_FLAGS, 32'h3);
    core_int_enable <= 1'b0;
    rdchk("pc clear", ADDR_FLAGS, 32'h0);
    wr(ADDR_CTRL_A, TPS_CS_EXT_RISE);
    wr(ADDR_CTRL_B, TPS_CS_EXT_FALL);
    {ca, cb, ru, fl} = '0;
    run <= 1'b1;
    count(40);
    run <= 1'b0;
    count(20);
    chk("edges seen", 1, ru > 2);
    chk("rise ticks", ru, ca);
    chk("fall ticks", fl, cb);
    rdchk("status idle", ADDR_STATUS, 32'h0);
    close_out;
  end
endmodule
